// file: design/relay_route_pkg.sv
// package: matrix geometry, encodings, reset values and command carriers
package relay_route_pkg;
   localparam int NUM_CARDS = 4;
   localparam int NUM_INPUTS = 10;
   localparam int NUM_OUTPUTS = 12;
   localparam int CARD_W = 3;
   localparam int PORT_W = 4;
   localparam int SEQ_PHASE_CYCLES = 1;
   localparam logic [3:0] RESET_BIAS_PORT = 4'hA;
   localparam logic [4:0] RESET_COUPLE_SET = 5'h00;
   localparam logic [2:0] CARD_ALL = 3'h7;

   typedef enum logic {
      free_rule = 1'b0,
      single_route_rule = 1'b1
   } rule_type;

   typedef enum logic [1:0] {
      no_sequence_mode = 2'b00,
      break_first_mode = 2'b01,
      make_first_mode = 2'b10
   } seq_type;

   localparam seq_type break_first_default = break_first_mode;

   typedef enum logic [2:0] {
      op_close = 3'b000,
      op_query_close = 3'b001,
      op_set_rule = 3'b010,
      op_set_seq = 3'b011,
      op_set_couple = 3'b100,
      op_set_bias = 3'b101,
      op_query_cfg = 3'b110
   } op_type;

   typedef struct packed {
      op_type op;
      logic [2:0] card;
      logic [3:0] in_port;
      logic [3:0] out_port;
      logic [1:0] value;
      logic [4:0] couple_set;
      logic bias_on;
      logic [3:0] bias_port;
   } cmd_type;

   typedef struct packed {
      logic done;
      logic rejected;
      logic status;
      rule_type rule;
      seq_type seq;
   } resp_type;
endpackage

// file: design/relay_card_cfg.sv
// one card's stored configuration: rule, sequence, coupling, bias
`timescale 1ns/1ps
`default_nettype none
module relay_card_cfg
   import relay_route_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // write strobe and fields
   input wire logic wr_rule,
   input wire logic wr_seq,
   input wire logic wr_couple,
   input wire logic wr_bias,
   input wire relay_route_pkg::cmd_type cmd,
   // stored state
   output rule_type rule_r,
   output seq_type seq_r,
   output logic [4:0] couple_r,
   output logic bias_on_r,
   output logic [3:0] bias_port_r
);
   rule_type rule_nxt;
   seq_type seq_nxt;
   logic [4:0] couple_nxt;
   logic bias_on_nxt;
   logic [3:0] bias_port_nxt;

   always_comb begin
      rule_nxt = rule_r;
      seq_nxt = seq_r;
      couple_nxt = couple_r;
      bias_on_nxt = bias_on_r;
      bias_port_nxt = bias_port_r;
      if (wr_rule) rule_nxt = rule_type'(cmd.value[0]);
      if (wr_seq) seq_nxt = seq_type'(cmd.value);
      if (wr_couple) couple_nxt = cmd.couple_set; // whole set replaced
      if (wr_bias) begin
         bias_on_nxt = cmd.bias_on;
         bias_port_nxt = cmd.bias_port;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         rule_r <= free_rule;
         seq_r <= break_first_default;
         couple_r <= RESET_COUPLE_SET;
         bias_on_r <= 1'b0;
         bias_port_r <= RESET_BIAS_PORT;
      end else begin
         rule_r <= rule_nxt;
         seq_r <= seq_nxt;
         couple_r <= couple_nxt;
         bias_on_r <= bias_on_nxt;
         bias_port_r <= bias_port_nxt;
      end
   end
endmodule // relay_card_cfg
`default_nettype wire

// file: design/relay_out_col.sv
// one output column of a card: which inputs, if any, drive it
`timescale 1ns/1ps
`default_nettype none
module relay_out_col
   import relay_route_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // column update
   input wire logic set_en,
   input wire logic [NUM_INPUTS-1:0] set_val,
   // relay state
   output logic [NUM_INPUTS-1:0] col_r
);
   logic [NUM_INPUTS-1:0] col_nxt;

   always_comb begin
      col_nxt = set_en ? set_val : col_r;
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) col_r <= '0;
      else col_r <= col_nxt;
   end
endmodule // relay_out_col
`default_nettype wire

// file: design/relay_matrix_route_control.sv
// route controller: closes relays, answers status and configuration queries
//
// Overview of operation
// - close joins listed input to listed output
// - bias mode rejects bias port as source
// - bias-tied output detached, then attached anew
// - status query answers 1 closed, 0 open
// - per-card free or single rule, or all
// - reset sets every card to free rule
// - rule query reports free or single token
// - sequence mode per card, reset break-first
// - sequencing applies on single-route cards only
// - coupled close uses odd output and next
// - new coupling set replaces the old one
// - reset leaves no inputs coupled
// - bias port equal to coupled port refused
// - coupling stored independently per card
// - multiplexer variant refuses coupling entirely
// - bias joins every free bias-enabled output
`timescale 1ns/1ps
`default_nettype none
module relay_matrix_route_control
   import relay_route_pkg::*;
#(
   parameter bit MUX_VARIANT = 1'b0
)(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // command port
   input wire logic cmd_valid,
   input wire relay_route_pkg::cmd_type cmd,
   output logic cmd_ready,
   // bias enable per card and output
   input wire logic [NUM_CARDS*NUM_OUTPUTS-1:0] bias_enable,
   // answer
   output relay_route_pkg::resp_type resp,
   // relay drive, card-major, output-major, input-minor
   output logic [NUM_CARDS*NUM_OUTPUTS*NUM_INPUTS-1:0] relay_drive
);
   import relay_route_pkg::*;

   typedef enum logic [1:0] {
      st_idle = 2'b00,
      st_first = 2'b01,
      st_second = 2'b10
   } state_type;

   rule_type rule_r [NUM_CARDS];
   seq_type seq_r [NUM_CARDS];
   logic [4:0] couple_r [NUM_CARDS];
   logic bias_on_r [NUM_CARDS];
   logic [3:0] bias_port_r [NUM_CARDS];
   logic [NUM_INPUTS-1:0] col_r [NUM_CARDS][NUM_OUTPUTS];
   logic [NUM_INPUTS-1:0] col_set [NUM_CARDS][NUM_OUTPUTS];
   logic col_en [NUM_CARDS][NUM_OUTPUTS];
   logic [NUM_CARDS-1:0] wr_rule, wr_seq, wr_couple, wr_bias;

   state_type state_r, state_nxt;
   cmd_type cur_r, cur_nxt;
   resp_type resp_r, resp_nxt;
   logic ready_r, ready_nxt;
   logic [NUM_CARDS*NUM_OUTPUTS*NUM_INPUTS-1:0] drive_r, drive_nxt;

   // one-hot input select, zero for out-of-range ports
   function automatic logic [NUM_INPUTS-1:0] in_hot(input logic [3:0] p);
      logic [NUM_INPUTS-1:0] v;
      v = '0;
      if (p >= 4'h1 && p <= 4'hA) v[p-4'h1] = 1'b1;
      return v;
   endfunction

   // coupled-set bit of an odd input 1,3,5,7,9
   function automatic logic is_coupled(input logic [4:0] set, input logic [3:0] p);
      logic r;
      r = 1'b0;
      if (p[0] && p <= 4'h9) r = set[p[3:1]];
      return r;
   endfunction

   genvar gc, go;
   generate
      for (gc = 0; gc < NUM_CARDS; gc++) begin : g_card
         relay_card_cfg u_cfg (
            .core_clk(core_clk),
            .rst_n(rst_n),
            .wr_rule(wr_rule[gc]),
            .wr_seq(wr_seq[gc]),
            .wr_couple(wr_couple[gc]),
            .wr_bias(wr_bias[gc]),
            .cmd(cur_r),
            .rule_r(rule_r[gc]),
            .seq_r(seq_r[gc]),
            .couple_r(couple_r[gc]),
            .bias_on_r(bias_on_r[gc]),
            .bias_port_r(bias_port_r[gc])
         );
         for (go = 0; go < NUM_OUTPUTS; go++) begin : g_out
            relay_out_col u_col (
               .core_clk(core_clk),
               .rst_n(rst_n),
               .set_en(col_en[gc][go]),
               .set_val(col_set[gc][go]),
               .col_r(col_r[gc][go])
            );
         end
      end
   endgenerate

   // decoded view of the command held in cur_r
   logic [1:0] cidx;
   logic card_ok, is_all;
   logic [3:0] lo_out, hi_out;
   logic pair, bad_close, bad_cfg;
   always_comb begin
      cidx = cur_r.card[1:0] - 2'h1;
      is_all = (cur_r.card == CARD_ALL);
      card_ok = (cur_r.card >= 3'h1) && (cur_r.card <= 3'h4);
      pair = !MUX_VARIANT && is_coupled(couple_r[cidx], cur_r.in_port);
      lo_out = pair ? {cur_r.out_port[3:1], 1'b1} & 4'hF : cur_r.out_port;
      if (pair && !cur_r.out_port[0]) lo_out = cur_r.out_port - 4'h1;
      hi_out = lo_out + 4'h1;
      bad_close = !card_ok || in_hot(cur_r.in_port) == '0 || cur_r.out_port == 4'h0
         || cur_r.out_port > 4'hC || (pair && hi_out > 4'hC)
         || (bias_on_r[cidx] && cur_r.in_port == bias_port_r[cidx]);
      bad_cfg = MUX_VARIANT && cur_r.op == op_set_couple && cur_r.couple_set != 5'h00;
      for (int c = 0; c < NUM_CARDS; c++) begin
         if ((is_all || cidx == c[1:0]) && cur_r.op == op_set_couple
               && is_coupled(cur_r.couple_set, bias_port_r[c])) bad_cfg = 1'b1;
         if ((is_all || cidx == c[1:0]) && cur_r.op == op_set_bias
               && is_coupled(couple_r[c], cur_r.bias_port)) bad_cfg = 1'b1;
      end
      if (!is_all && !card_ok) bad_cfg = 1'b1;
   end

   always_comb begin
      state_nxt = state_r;
      cur_nxt = cur_r;
      resp_nxt = resp_r;
      resp_nxt.done = 1'b0;
      ready_nxt = ready_r;
      wr_rule = '0;
      wr_seq = '0;
      wr_couple = '0;
      wr_bias = '0;
      for (int c = 0; c < NUM_CARDS; c++) begin
         for (int o = 0; o < NUM_OUTPUTS; o++) begin
            col_en[c][o] = 1'b0;
            col_set[c][o] = col_r[c][o];
            // idle bias outputs follow the bias port
            if (bias_on_r[c] && bias_enable[c*NUM_OUTPUTS+o]
                  && (col_r[c][o] & ~in_hot(bias_port_r[c])) == '0) begin
               col_en[c][o] = 1'b1;
               col_set[c][o] = in_hot(bias_port_r[c]);
            end
         end
      end
      unique case (state_r)
         st_idle: begin
            if (cmd_valid && ready_r) begin
               cur_nxt = cmd;
               ready_nxt = 1'b0;
               state_nxt = st_first;
            end else if (!cmd_valid) begin
               ready_nxt = 1'b1;
            end
         end
         st_first: begin
            state_nxt = st_idle;
            ready_nxt = 1'b1;
            resp_nxt.done = 1'b1;
            resp_nxt.rejected = 1'b0;
            resp_nxt.status = 1'b0;
            unique case (cur_r.op)
               op_close: begin
                  if (bad_close) resp_nxt.rejected = 1'b1;
                  else if (rule_r[cidx] == single_route_rule
                        && seq_r[cidx] != no_sequence_mode) begin
                     // phase one: break-first drops the old route, make-first adds the new
                     for (int o = 0; o < NUM_OUTPUTS; o++) begin
                        if (o + 1 == lo_out || (pair && o + 1 == hi_out)) begin
                           col_en[cidx][o] = 1'b1;
                           col_set[cidx][o] = (seq_r[cidx] == break_first_mode) ? '0
                              : col_r[cidx][o] | in_hot(o + 1 == lo_out ? cur_r.in_port
                                 : cur_r.in_port + 4'h1);
                        end
                     end
                     resp_nxt.done = 1'b0;
                     ready_nxt = 1'b0;
                     state_nxt = st_second;
                  end else begin
                     for (int o = 0; o < NUM_OUTPUTS; o++) begin
                        if (o + 1 == lo_out || (pair && o + 1 == hi_out)) begin
                           col_en[cidx][o] = 1'b1;
                           // bias relay dropped as the new one closes
                           col_set[cidx][o] = (col_r[cidx][o] & ~(bias_on_r[cidx]
                              ? in_hot(bias_port_r[cidx]) : '0))
                              | in_hot(o + 1 == lo_out ? cur_r.in_port
                                 : cur_r.in_port + 4'h1);
                        end
                     end
                  end
               end
               op_query_close: begin
                  if (!card_ok || cur_r.out_port == 4'h0 || cur_r.out_port > 4'hC)
                     resp_nxt.rejected = 1'b1;
                  else resp_nxt.status = |(col_r[cidx][cur_r.out_port - 4'h1]
                     & in_hot(cur_r.in_port));
               end
               op_query_cfg: begin
                  if (!card_ok) resp_nxt.rejected = 1'b1;
                  else begin
                     resp_nxt.rule = rule_r[cidx];
                     resp_nxt.seq = seq_r[cidx];
                  end
               end
               default: begin
                  if (bad_cfg) resp_nxt.rejected = 1'b1;
                  else begin
                     for (int c = 0; c < NUM_CARDS; c++) begin
                        if (is_all || cidx == c[1:0]) begin
                           wr_rule[c] = (cur_r.op == op_set_rule);
                           wr_seq[c] = (cur_r.op == op_set_seq) && cur_r.value != 2'b11;
                           wr_couple[c] = (cur_r.op == op_set_couple);
                           wr_bias[c] = (cur_r.op == op_set_bias);
                        end
                     end
                  end
               end
            endcase
         end
         st_second: begin
            state_nxt = st_idle;
            ready_nxt = 1'b1;
            resp_nxt.done = 1'b1;
            for (int o = 0; o < NUM_OUTPUTS; o++) begin
               if (o + 1 == lo_out || (pair && o + 1 == hi_out)) begin
                  col_en[cidx][o] = 1'b1;
                  col_set[cidx][o] = in_hot(o + 1 == lo_out ? cur_r.in_port
                     : cur_r.in_port + 4'h1); // old opens last or new closes now
               end
            end
         end
         default: state_nxt = st_idle;
      endcase
      for (int c = 0; c < NUM_CARDS; c++)
         for (int o = 0; o < NUM_OUTPUTS; o++)
            drive_nxt[(c*NUM_OUTPUTS+o)*NUM_INPUTS +: NUM_INPUTS] = col_en[c][o] ? col_set[c][o]
               : col_r[c][o];
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         state_r <= st_idle;
         cur_r <= '0;
         resp_r <= '{done: 1'b0, rejected: 1'b0, status: 1'b0, rule: free_rule,
            seq: break_first_default};
         ready_r <= 1'b0;
         drive_r <= '0;
      end else begin
         state_r <= state_nxt;
         cur_r <= cur_nxt;
         resp_r <= resp_nxt;
         ready_r <= ready_nxt;
         drive_r <= drive_nxt;
      end
   end

   assign cmd_ready = ready_r;
   assign resp = resp_r;
   assign relay_drive = drive_r;

   // a close from the bias port as source is rejected while bias is on
   a_reject_bias_src: assert property (@(posedge core_clk) disable iff (!rst_n)
      state_r == st_first && cur_r.op == op_close && bias_on_r[cidx]
      && cur_r.in_port == bias_port_r[cidx] |=> resp_r.rejected && resp_r.done)
      else $error("bias port accepted as close source");
   a_close_done: assert property (@(posedge core_clk) disable iff (!rst_n)
      state_r == st_first && cur_r.op == op_close && !bad_close
      && rule_r[cidx] == free_rule |=> resp_r.done && !resp_r.rejected)
      else $error("free-route close did not finish in one step");
   a_seq_two_step: assert property (@(posedge core_clk) disable iff (!rst_n)
      state_r == st_first && cur_r.op == op_close && !bad_close
      && rule_r[cidx] == single_route_rule && seq_r[cidx] != no_sequence_mode
      |=> state_r == st_second ##1 resp_r.done)
      else $error("sequenced close skipped its second phase");
   a_break_first: assert property (@(posedge core_clk) disable iff (!rst_n)
      state_r == st_first && cur_r.op == op_close && !bad_close
      && rule_r[cidx] == single_route_rule && seq_r[cidx] == break_first_mode
      |=> col_r[cidx][lo_out - 4'h1] == '0)
      else $error("old route not broken before make");
   a_make_first: assert property (@(posedge core_clk) disable iff (!rst_n)
      state_r == st_first && cur_r.op == op_close && !bad_close
      && rule_r[cidx] == single_route_rule && seq_r[cidx] == make_first_mode
      |=> (col_r[cidx][lo_out - 4'h1] & in_hot(cur_r.in_port)) != '0)
      else $error("new route not made before break");
   a_reset_rule: assert property (@(posedge core_clk)
      $rose(rst_n) |-> rule_r[0] == free_rule && seq_r[0] == break_first_mode
      && couple_r[0] == 5'h00)
      else $error("card defaults wrong after reset");
   a_bias_couple: assert property (@(posedge core_clk) disable iff (!rst_n)
      state_r == st_first && cur_r.op == op_set_bias && card_ok
      && is_coupled(couple_r[cidx], cur_r.bias_port) |=> resp_r.rejected)
      else $error("bias port clash with couple port accepted");
   a_mux_couple: assert property (@(posedge core_clk) disable iff (!rst_n)
      state_r == st_first && cur_r.op == op_set_couple && card_ok
      |=> MUX_VARIANT ? couple_r[cidx] == 5'h00 : (resp_r.rejected || couple_r[cidx] == cur_r.couple_set))
      else $error("coupling set stored wrongly");
   a_query_card: assert property (@(posedge core_clk) disable iff (!rst_n)
      state_r == st_first && cur_r.op == op_query_cfg && is_all |=> resp_r.rejected)
      else $error("query to all cards answered");
   c_close: cover property (@(posedge core_clk) state_r == st_first && cur_r.op == op_close);
   c_seq: cover property (@(posedge core_clk) state_r == st_second);
   c_query: cover property (@(posedge core_clk) resp_r.done && resp_r.status);
endmodule // relay_matrix_route_control
`default_nettype wire

// file: dv/relay_host_model.sv
// host model: offers routing commands one at a time and waits for each answer
`timescale 1ns/1ps
`default_nettype none
module relay_host_model
   import relay_route_pkg::*;
(
   // clock
   input wire logic core_clk,
   // command port
   output logic cmd_valid,
   output relay_route_pkg::cmd_type cmd,
   input wire logic cmd_ready,
   // answer
   input wire relay_route_pkg::resp_type resp
);
   import relay_route_pkg::*;

   logic timed_out;

   initial begin
      cmd_valid = 1'b0;
      cmd = '0;
      timed_out = 1'b0;
   end

   // callers choose card codes 1..4 or all for settings and one card for queries
   // odd inputs only in couple_set: bit i stands for input 2i+1 paired with 2i+2
   task automatic send(input cmd_type c);
      int n;
      n = 0;
      @(negedge core_clk);
      while (cmd_ready !== 1'b1 && n < 50) begin
         @(negedge core_clk);
         n++;
      end
      cmd = c;
      cmd_valid = 1'b1;
      // request stands until the edge that takes it
      n = 0;
      @(posedge core_clk);
      while (cmd_ready !== 1'b1 && n < 50) begin
         @(posedge core_clk);
         n++;
      end
      @(negedge core_clk);
      cmd_valid = 1'b0;
      // idle bus shows an inverted pattern, not the last command
      cmd = ~c;
      n = 0;
      while (resp.done !== 1'b1 && n < 10) begin
         @(negedge core_clk);
         n++;
      end
      timed_out = (resp.done !== 1'b1);
   endtask
endmodule // relay_host_model
`default_nettype wire

// file: dv/testbench.sv
// testbench: close, query, rule, sequence, bias and coupling scenarios
`timescale 1ns/1ps
`default_nettype none
`define check(name, exp, got) \
   begin \
      samples_checked++; \
      if ((got) !== (exp)) begin \
         n_mismatch++; \
         $display("mismatch %s expected %h seen %h", name, exp, got); \
      end \
   end
module testbench;
   import relay_route_pkg::*;

   logic core_clk;
   logic rst_n;
   logic cmd_valid;
   cmd_type cmd;
   logic cmd_ready;
   logic [NUM_CARDS*NUM_OUTPUTS-1:0] bias_enable;
   resp_type resp;
   logic [NUM_CARDS*NUM_OUTPUTS*NUM_INPUTS-1:0] relay_drive;
   int n_mismatch = 0;
   int samples_checked = 0;

   relay_matrix_route_control uut (
      .core_clk(core_clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
      .bias_enable(bias_enable), .resp(resp), .relay_drive(relay_drive));

   relay_host_model host (
      .core_clk(core_clk), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .resp(resp));

   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   function automatic cmd_type mk(op_type op, logic [2:0] card, logic [3:0] inp, logic [3:0] outp,
                                  logic [1:0] value);
      cmd_type c;
      c = '0;
      c.op = op;
      c.card = card;
      c.in_port = inp;
      c.out_port = outp;
      c.value = value;
      c.bias_port = RESET_BIAS_PORT;
      return c;
   endfunction

   function automatic logic relay(int card, int inp, int outp);
      return relay_drive[((card-1)*NUM_OUTPUTS+(outp-1))*NUM_INPUTS+(inp-1)];
   endfunction

   task automatic go(input cmd_type c);
      host.send(c);
      `check("answer", 1'b0, host.timed_out)
   endtask

   task automatic t_reset;
      `check("relays", '0, relay_drive)
      go(mk(op_query_cfg, 3'h2, 4'h0, 4'h0, 2'h0));
      `check("rule", free_rule, resp.rule)
      `check("seq", break_first_default, resp.seq)
   endtask

   task automatic t_close;
      go(mk(op_close, 3'h1, 4'h1, 4'h1, 2'h0));
      go(mk(op_close, 3'h1, 4'h2, 4'h2, 2'h0));
      `check("in1 out1", 1'b1, relay(1, 1, 1))
      `check("in2 out2", 1'b1, relay(1, 2, 2))
      `check("in1 out2", 1'b0, relay(1, 1, 2))
      go(mk(op_query_close, 3'h1, 4'h1, 4'h1, 2'h0));
      `check("closed", 1'b1, resp.status)
      go(mk(op_query_close, 3'h1, 4'h1, 4'h2, 2'h0));
      `check("open", 1'b0, resp.status)
   endtask

   task automatic t_rule_seq;
      go(mk(op_set_rule, CARD_ALL, 4'h0, 4'h0, 2'h1));
      go(mk(op_query_cfg, 3'h3, 4'h0, 4'h0, 2'h0));
      `check("rule all", single_route_rule, resp.rule)
      go(mk(op_set_rule, 3'h4, 4'h0, 4'h0, 2'h0));
      go(mk(op_query_cfg, 3'h4, 4'h0, 4'h0, 2'h0));
      `check("rule one", free_rule, resp.rule)
      for (int m = 0; m < 3; m++) begin
         go(mk(op_set_seq, 3'h2, 4'h0, 4'h0, 2'(m)));
         go(mk(op_query_cfg, 3'h2, 4'h0, 4'h0, 2'h0));
         `check("seq", seq_type'(m), resp.seq)
      end
      go(mk(op_query_cfg, 3'h1, 4'h0, 4'h0, 2'h0));
      `check("seq other card", break_first_default, resp.seq)
      go(mk(op_query_cfg, CARD_ALL, 4'h0, 4'h0, 2'h0));
      `check("query all", 1'b1, resp.rejected)
   endtask

   task automatic t_bias;
      cmd_type c;
      // card 1 output 4 is left out of the bias set
      bias_enable[3] = 1'b0;
      c = mk(op_set_bias, 3'h1, 4'h0, 4'h0, 2'h0);
      c.bias_on = 1'b1;
      go(c);
      repeat (2) @(negedge core_clk);
      `check("bias free out", 1'b1, relay(1, 10, 3))
      `check("bias busy out", 1'b0, relay(1, 10, 1))
      `check("bias disabled out", 1'b0, relay(1, 10, 4))
      go(mk(op_close, 3'h1, 4'hA, 4'h5, 2'h0));
      `check("bias source", 1'b1, resp.rejected)
      go(mk(op_close, 3'h1, 4'h3, 4'h3, 2'h0));
      repeat (2) @(negedge core_clk);
      `check("detached", 1'b0, relay(1, 10, 3))
      `check("attached", 1'b1, relay(1, 3, 3))
   endtask

   task automatic t_couple;
      cmd_type c;
      c = mk(op_set_couple, 3'h3, 4'h0, 4'h0, 2'h0);
      c.couple_set = 5'h01;
      go(c);
      go(mk(op_close, 3'h3, 4'h1, 4'h4, 2'h0));
      `check("pair low", 1'b1, relay(3, 1, 3))
      `check("pair high", 1'b1, relay(3, 2, 4))
      go(mk(op_close, 3'h4, 4'h1, 4'h7, 2'h0));
      `check("other card", 1'b0, relay(4, 2, 8))
      c.couple_set = 5'h02;
      go(c);
      go(mk(op_close, 3'h3, 4'h1, 4'h7, 2'h0));
      `check("replaced", 1'b0, relay(3, 2, 8))
      `check("single", 1'b1, relay(3, 1, 7))
      c = mk(op_set_bias, 3'h3, 4'h0, 4'h0, 2'h0);
      c.bias_port = 4'h3;
      go(c);
      `check("bias clash", 1'b1, resp.rejected)
   endtask

   // card 2 is single route in make-first mode; card 4 is free route
   task automatic t_make_first;
      cmd_type c;
      go(mk(op_close, 3'h2, 4'h1, 4'h1, 2'h0));
      go(mk(op_close, 3'h2, 4'h3, 4'h1, 2'h0));
      `check("make new", 1'b1, relay(2, 3, 1))
      `check("break old", 1'b0, relay(2, 1, 1))
      c = mk(op_set_bias, 3'h4, 4'h0, 4'h0, 2'h0);
      c.bias_on = 1'b1;
      go(c);
      repeat (2) @(negedge core_clk);
      go(mk(op_close, 3'h4, 4'h3, 4'h5, 2'h0));
      `check("free detached", 1'b0, relay(4, 10, 5))
      `check("free attached", 1'b1, relay(4, 3, 5))
      `check("busy kept", 1'b0, relay(4, 10, 7))
   endtask

   task automatic results;
      $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // every command takes under ten cycles; this span is many times the whole run
   initial begin
      #(20 * 5000);
      n_mismatch++;
      results();
   end

   initial begin
      rst_n = 1'b0;
      bias_enable = '1;
      repeat (12) @(negedge core_clk);
      rst_n = 1'b1;
      t_reset();
      t_close();
      t_rule_seq();
      t_bias();
      t_couple();
      t_make_first();
      results();
   end
endmodule // testbench
`default_nettype wire
